/* File: logic/ieu_params.svh */
`ifndef IEU_PARAMS_SVH
`define IEU_PARAMS_SVH

// Vector addressing
`define IEU_ADDR_W          20
`define IEU_VEC_BYTES       4
`define IEU_FIXED_BASE      20'h0ffdc
`define IEU_FIXED_LAST      20'h0ffff
`define IEU_RELOC_SPAN      256

// Fixed vector slots, counted in entries from the fixed base
`define IEU_SLOT_UNDEF      4'h0
`define IEU_SLOT_OVF        4'h1
`define IEU_SLOT_BRK        4'h2
`define IEU_SLOT_MATCH      4'h3
`define IEU_SLOT_SSTEP      4'h4
`define IEU_SLOT_WDT_GRP    4'h5
`define IEU_SLOT_ABRK       4'h6
`define IEU_SLOT_RESET      4'h8

// Software interrupt numbering
`define IEU_NUM_W           6
`define IEU_NUM_MAX         6'h3f
`define IEU_NUM_U_LAST      6'h1f
`define IEU_PERIPH_FIRST    6'h04
`define IEU_PERIPH_COUNT    28
`define IEU_BRK_RELOC_NUM   6'h00

// Priority level width and reset values
`define IEU_LVL_W           3
`define IEU_U_FLAG_RST      1'b0

`endif

/* File: logic/ieu_pkg.sv */
package ieu_pkg;

   // Request source class held while a request is presented
   typedef enum logic [3:0] {
      IEU_SRC_NONE   = 4'h0,
      IEU_SRC_UNDEF  = 4'h1,
      IEU_SRC_OVF    = 4'h2,
      IEU_SRC_BRK    = 4'h3,
      IEU_SRC_INT    = 4'h4,
      IEU_SRC_MATCH  = 4'h5,
      IEU_SRC_WDT    = 4'h6,
      IEU_SRC_OSC    = 4'h7,
      IEU_SRC_VMON2  = 4'h8,
      IEU_SRC_SSTEP  = 4'h9,
      IEU_SRC_ABRK   = 4'ha,
      IEU_SRC_PERIPH = 4'hb
   } ieu_src_e;

   typedef enum logic [0:0] {
      IEU_ST_IDLE = 1'b0,
      IEU_ST_WAIT = 1'b1
   } ieu_state_e;

   // Trapping instruction reported by the decoder, one-cycle pulses
   typedef struct packed {
      logic       undefined_opcode_instr;
      logic       overflow_trap_instr;
      logic       break_instr;
      logic       int_instr;
      logic [5:0] int_num;
   } ieu_trap_s;

   // Special (non-maskable) hardware sources, levels or pulses
   typedef struct packed {
      logic watchdog;
      logic osc_stop;
      logic volt_mon2;
      logic single_step;
      logic addr_break;
   } ieu_special_s;

   // Request presented to the sequencer
   typedef struct packed {
      logic        valid;
      ieu_src_e    src;
      logic [5:0]  num;
      logic        save_u;
      logic [19:0] vector_addr;
   } ieu_req_s;

endpackage : ieu_pkg

/* File: logic/ieu_prio_resolve.sv */
`timescale 1ns/1ps
`include "ieu_params.svh"

// Picks the pending peripheral with the highest level; ties go to the
// lowest index. Level zero means the source is disabled.
module ieu_prio_resolve #(
   parameter int N     = `IEU_PERIPH_COUNT,
   parameter int LVL_W = `IEU_LVL_W,
   parameter int IDX_W = 5
) (
   input  wire logic [N-1:0]       pend_in,
   input  wire logic [N*LVL_W-1:0] level_in,
   output logic                    hit_out,
   output logic [IDX_W-1:0]        idx_out,
   output logic [LVL_W-1:0]        level_out
);

   logic [LVL_W-1:0] best_lvl [0:N];
   logic [IDX_W-1:0] best_idx [0:N];

   assign best_lvl[0] = '0;
   assign best_idx[0] = '0;

   // Compare chain; strict greater keeps the lower index on a tie
   for (genvar i = 0; i < N; i++) begin : g_cmp
      logic [LVL_W-1:0] lvl;
      logic             wins;
      assign lvl  = level_in[i*LVL_W +: LVL_W];
      assign wins = pend_in[i] && (lvl > best_lvl[i]);
      assign best_lvl[i+1] = wins ? lvl : best_lvl[i];
      assign best_idx[i+1] = wins ? IDX_W'(i) : best_idx[i];
   end

   assign hit_out   = (best_lvl[N] != '0);
   assign idx_out   = best_idx[N];
   assign level_out = best_lvl[N];

endmodule : ieu_prio_resolve

/* File: logic/ieu_exception_unit.sv */
`timescale 1ns/1ps
`include "ieu_params.svh"

module ieu_exception_unit #(
   parameter int N_PERIPH = `IEU_PERIPH_COUNT,
   parameter int LVL_W    = `IEU_LVL_W,
   parameter int ADDR_W   = `IEU_ADDR_W
) (
   input  wire logic                      clock_in,
   input  wire logic                      rst_n_in,
   input  wire logic                      i_flag_in,
   input  wire logic [LVL_W-1:0]          cpu_level_in,
   input  wire logic                      overflow_flag_in,
   input  wire ieu_pkg::ieu_trap_s        trap_in,
   input  wire logic                      brk_use_reloc_in,
   input  wire ieu_pkg::ieu_special_s     special_in,
   input  wire logic                      fetch_valid_in,
   input  wire logic [ADDR_W-1:0]         fetch_addr_in,
   input  wire logic [ADDR_W-1:0]         match_address_0_in,
   input  wire logic [ADDR_W-1:0]         match_address_1_in,
   input  wire logic                      match_enable_0_in,
   input  wire logic                      match_enable_1_in,
   input  wire logic [ADDR_W-1:0]         vector_base_reg_in,
   input  wire logic [N_PERIPH-1:0]       periph_req_in,
   input  wire logic [N_PERIPH*LVL_W-1:0] periph_level_in,
   input  wire logic                      ack_in,
   input  wire logic                      return_in,
   input  wire logic                      return_restore_u_in,
   input  wire logic                      return_u_in,
   input  wire logic                      u_write_in,
   input  wire logic                      u_write_val_in,
   output ieu_pkg::ieu_req_s              req_out,
   output logic                           u_push_out,
   output logic                           u_push_val_out,
   output logic                           u_flag_out,
   output logic [N_PERIPH-1:0]            periph_pend_out
);
   import ieu_pkg::*;

   localparam int IDX_W = $clog2(N_PERIPH);

   // Latched special, instruction and peripheral requests
   logic                undef_q;
   logic                ovf_q;
   logic                brk_q;
   logic                int_q;
   logic [5:0]          int_num_q;
   logic                match_q;
   logic                wdt_q;
   logic                osc_q;
   logic                vmon_q;
   logic                sstep_q;
   logic                abrk_q;
   logic [N_PERIPH-1:0] periph_q;

   ieu_state_e          state_q;
   ieu_req_s            req_q;
   logic [IDX_W-1:0]    req_idx_q;
   logic                u_flag_q;
   logic                u_push_q;
   logic                u_push_val_q;

   // Combinational winner
   ieu_req_s            sel_d;
   logic [IDX_W-1:0]    sel_idx_d;
   logic                p_hit;
   logic [IDX_W-1:0]    p_idx;
   logic [LVL_W-1:0]    p_lvl;
   logic                match_hit;
   logic                taken;

   // Acknowledge closes the current request this cycle
   assign taken = (state_q == IEU_ST_WAIT) && ack_in;

   // Address compare at fetch, before the instruction runs
   assign match_hit = fetch_valid_in &&
      ((match_enable_0_in && fetch_addr_in == match_address_0_in) ||
       (match_enable_1_in && fetch_addr_in == match_address_1_in));

   ieu_prio_resolve #(
      .N     (N_PERIPH),
      .LVL_W (LVL_W),
      .IDX_W (IDX_W)
   ) u_prio (
      .pend_in   (periph_q),
      .level_in  (periph_level_in),
      .hit_out   (p_hit),
      .idx_out   (p_idx),
      .level_out (p_lvl)
   );

   // Entry address inside the fixed table
   function automatic logic [19:0] fixed_vec(input logic [3:0] slot);
      fixed_vec = `IEU_FIXED_BASE +
                  20'({slot, 2'b00});
   endfunction : fixed_vec

   // Entry address inside the relocatable table; base plus four bytes per number, no wrap within its span
   function automatic logic [19:0] reloc_vec(input logic [19:0] base,
                                             input logic [5:0]  num);
      reloc_vec = base + 20'({num, 2'b00});
   endfunction : reloc_vec

   // Instruction traps are set on the decode pulse, the overflow trap only with overflow_flag_in set; set wins over clear
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         undef_q   <= 1'b0;
         ovf_q     <= 1'b0;
         brk_q     <= 1'b0;
         int_q     <= 1'b0;
         int_num_q <= 6'h00;
      end else begin
         if (taken && req_q.src == IEU_SRC_UNDEF)
            undef_q <= 1'b0;
         if (trap_in.undefined_opcode_instr)
            undef_q <= 1'b1;
         if (taken && req_q.src == IEU_SRC_OVF)
            ovf_q <= 1'b0;
         if (trap_in.overflow_trap_instr && overflow_flag_in)
            ovf_q <= 1'b1;
         if (taken && req_q.src == IEU_SRC_BRK)
            brk_q <= 1'b0;
         if (trap_in.break_instr)
            brk_q <= 1'b1;
         if (taken && req_q.src == IEU_SRC_INT)
            int_q <= 1'b0;
         if (trap_in.int_instr) begin
            int_q     <= 1'b1;
            int_num_q <= trap_in.int_num & `IEU_NUM_MAX;
         end
      end
   end

   // Special sources stay latched until acknowledged
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         match_q <= 1'b0;
         wdt_q   <= 1'b0;
         osc_q   <= 1'b0;
         vmon_q  <= 1'b0;
         sstep_q <= 1'b0;
         abrk_q  <= 1'b0;
      end else begin
         match_q <= (match_q & ~(taken && req_q.src == IEU_SRC_MATCH))
                    | match_hit;
         wdt_q   <= (wdt_q & ~(taken && req_q.src == IEU_SRC_WDT))
                    | special_in.watchdog;
         osc_q   <= (osc_q & ~(taken && req_q.src == IEU_SRC_OSC))
                    | special_in.osc_stop;
         vmon_q  <= (vmon_q & ~(taken && req_q.src == IEU_SRC_VMON2))
                    | special_in.volt_mon2;
         sstep_q <= (sstep_q & ~(taken && req_q.src == IEU_SRC_SSTEP))
                    | special_in.single_step;
         abrk_q  <= (abrk_q & ~(taken && req_q.src == IEU_SRC_ABRK))
                    | special_in.addr_break;
      end
   end

   // Peripheral requests latch per source; a new pulse beats the clear
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         periph_q <= '0;
      end else begin
         for (int i = 0; i < N_PERIPH; i++) begin
            if (taken && req_q.src == IEU_SRC_PERIPH &&
                req_idx_q == IDX_W'(i))
               periph_q[i] <= 1'b0;
            if (periph_req_in[i])
               periph_q[i] <= 1'b1;
         end
      end
   end

   // Fixed order among non-maskable sources, then maskable by level.
   // Instruction traps come first since they belong to the running
   // instruction and must be serviced before anything else intervenes.
   always_comb begin
      sel_d             = '0;
      sel_idx_d         = '0;
      sel_d.src         = IEU_SRC_NONE;
      sel_d.valid       = 1'b1;
      sel_d.save_u      = 1'b1;
      if (undef_q) begin
         sel_d.src         = IEU_SRC_UNDEF;
         sel_d.vector_addr = fixed_vec(`IEU_SLOT_UNDEF);
      end else if (ovf_q) begin
         sel_d.src         = IEU_SRC_OVF;
         sel_d.vector_addr = fixed_vec(`IEU_SLOT_OVF);
      end else if (brk_q) begin
         sel_d.src         = IEU_SRC_BRK;
         sel_d.num         = `IEU_BRK_RELOC_NUM;
         sel_d.vector_addr = brk_use_reloc_in
            ? reloc_vec(vector_base_reg_in, `IEU_BRK_RELOC_NUM)
            : fixed_vec(`IEU_SLOT_BRK);
      end else if (int_q) begin
         sel_d.src         = IEU_SRC_INT;
         sel_d.num         = int_num_q;
         sel_d.save_u      = (int_num_q <= `IEU_NUM_U_LAST);
         sel_d.vector_addr = reloc_vec(vector_base_reg_in,
                                       int_num_q);
      end else if (match_q) begin
         sel_d.src         = IEU_SRC_MATCH;
         sel_d.vector_addr = fixed_vec(`IEU_SLOT_MATCH);
      end else if (wdt_q || osc_q || vmon_q) begin
         // One shared entry; handler tells the three apart by status
         sel_d.src         = wdt_q ? IEU_SRC_WDT
                           : (osc_q ? IEU_SRC_OSC : IEU_SRC_VMON2);
         sel_d.vector_addr = fixed_vec(`IEU_SLOT_WDT_GRP);
      end else if (sstep_q) begin
         sel_d.src         = IEU_SRC_SSTEP;
         sel_d.vector_addr = fixed_vec(`IEU_SLOT_SSTEP);
      end else if (abrk_q) begin
         sel_d.src         = IEU_SRC_ABRK;
         sel_d.vector_addr = fixed_vec(`IEU_SLOT_ABRK);
      end else if (i_flag_in && p_hit && p_lvl > cpu_level_in) begin
         sel_d.src         = IEU_SRC_PERIPH;
         sel_idx_d         = p_idx;
         sel_d.num         = `IEU_PERIPH_FIRST + 6'(p_idx);
         sel_d.vector_addr = reloc_vec(vector_base_reg_in, sel_d.num);
      end else begin
         sel_d.valid       = 1'b0;
         sel_d.save_u      = 1'b0;
      end
   end

   // Present one request and hold it until the sequencer takes it.
   // The held vector does not re-arbitrate, so a higher source that
   // appears meanwhile waits for the next idle cycle.
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q   <= IEU_ST_IDLE;
         req_q     <= '0;
         req_idx_q <= '0;
      end else begin
         case (state_q)
            IEU_ST_IDLE: begin
               if (sel_d.valid) begin
                  req_q     <= sel_d;
                  req_idx_q <= sel_idx_d;
                  state_q   <= IEU_ST_WAIT;
               end
            end
            IEU_ST_WAIT: begin
               if (ack_in) begin
                  req_q.valid <= 1'b0;
                  state_q     <= IEU_ST_IDLE;
               end
            end
            default: begin
               req_q.valid <= 1'b0;
               state_q     <= IEU_ST_IDLE;
            end
         endcase
      end
   end

   // Stack-select flag: save and clear on entry when save_u is set, restore on return when return_restore_u_in is set
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         u_flag_q     <= `IEU_U_FLAG_RST;
         u_push_q     <= 1'b0;
         u_push_val_q <= 1'b0;
      end else begin
         u_push_q <= 1'b0;
         if (taken && req_q.save_u) begin
            u_push_q     <= 1'b1;
            u_push_val_q <= u_flag_q;
            u_flag_q     <= 1'b0;
         end else if (return_in && return_restore_u_in) begin
            u_flag_q <= return_u_in;
         end else if (u_write_in) begin
            u_flag_q <= u_write_val_in;
         end
      end
   end

   // All outputs come from flip-flops
   assign req_out         = req_q;
   assign u_push_out      = u_push_q;
   assign u_push_val_out  = u_push_val_q;
   assign u_flag_out      = u_flag_q;
   assign periph_pend_out = periph_q;

endmodule : ieu_exception_unit

/* File: dv/ieu_seq_model.sv */
`timescale 1ns/1ps
// Stand-in for the core sequencer that consumes presented requests
module ieu_seq_model (
   input  wire logic              clock_in,
   input  wire logic              rst_n_in,
   input  wire ieu_pkg::ieu_req_s req_in,
   input  wire logic              slow_in,
   output logic                   ack_out,
   output logic                   took_out,
   output ieu_pkg::ieu_req_s      taken_out
);
   import ieu_pkg::*;
   logic [1:0] wait_q;

   // Ack at once or after a stall; ack is a pulse, so drop it straight away
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_out <= 1'b0;
         wait_q  <= 2'h0;
      end else if (ack_out) begin
         ack_out <= 1'b0;
         wait_q  <= 2'h0;
      end else if (req_in.valid) begin
         if (!slow_in || wait_q == 2'h3) begin
            ack_out <= 1'b1;
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end

   // Keep the entry the core would load its program counter from
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         took_out  <= 1'b0;
         taken_out <= '0;
      end else begin
         took_out <= ack_out && req_in.valid;
         if (ack_out && req_in.valid) begin
            taken_out <= req_in;
         end
      end
   end
endmodule : ieu_seq_model

/* File: dv/ieu_exception_unit_sva.sv */
`timescale 1ns/1ps
// Watches the request port against trap, mask and stack-flag behaviour
module ieu_checker #(
   parameter int N_PERIPH = 28,
   parameter int LVL_W    = 3,
   parameter int ADDR_W   = 20
) (
   input wire logic                      clock_in,
   input wire logic                      rst_n_in,
   input wire logic                      i_flag_in,
   input wire logic [LVL_W-1:0]          cpu_level_in,
   input wire logic                      overflow_flag_in,
   input wire ieu_pkg::ieu_trap_s        trap_in,
   input wire logic                      brk_use_reloc_in,
   input wire ieu_pkg::ieu_special_s     special_in,
   input wire logic [ADDR_W-1:0]         vector_base_reg_in,
   input wire logic [N_PERIPH-1:0]       periph_req_in,
   input wire logic [N_PERIPH*LVL_W-1:0] periph_level_in,
   input wire logic                      ack_in,
   input wire ieu_pkg::ieu_req_s         req_out,
   input wire logic                      u_push_out,
   input wire logic                      u_push_val_out,
   input wire logic                      u_flag_out,
   input wire logic [N_PERIPH-1:0]       periph_pend_out
);
   import ieu_pkg::*;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   // Entry index within the fixed table; the shared group is the default
   function automatic logic [3:0] fslot(ieu_src_e s);
      case (s)
         IEU_SRC_UNDEF: return 4'h0;
         IEU_SRC_OVF:   return 4'h1;
         IEU_SRC_BRK:   return 4'h2;
         IEU_SRC_MATCH: return 4'h3;
         IEU_SRC_SSTEP: return 4'h4;
         IEU_SRC_ABRK:  return 4'h6;
         default:       return 4'h5;
      endcase
   endfunction : fslot

   sequence s_ack_save;
      req_out.valid && ack_in && req_out.save_u;
   endsequence
   sequence s_undef_idle;
      !req_out.valid && trap_in.undefined_opcode_instr;
   endsequence
   sequence s_wdt_idle;
      !req_out.valid && special_in.watchdog && trap_in == '0;
   endsequence
   sequence s_periph_rise;
      !req_out.valid ##1 req_out.valid && req_out.src == IEU_SRC_PERIPH;
   endsequence

   property p_hold;
      req_out.valid && !ack_in |=> req_out.valid && $stable(req_out);
   endproperty
   property p_save;
      s_ack_save |=> u_push_out && !u_flag_out && !req_out.valid
         && u_push_val_out == $past(u_flag_out);
   endproperty
   property p_int;
      req_out.valid && req_out.src == IEU_SRC_INT |->
         req_out.vector_addr == vector_base_reg_in + {req_out.num, 2'b00}
         && req_out.save_u == (req_out.num <= 6'h1f);
   endproperty
   property p_fixed;
      req_out.valid && !(req_out.src inside {IEU_SRC_INT, IEU_SRC_PERIPH})
         && !(req_out.src == IEU_SRC_BRK && brk_use_reloc_in) |->
         req_out.vector_addr == 20'h0ffdc + {fslot(req_out.src), 2'b00};
   endproperty
   property p_undef;
      s_undef_idle |-> ##2 req_out.valid && req_out.src == IEU_SRC_UNDEF;
   endproperty
   property p_ovf_drop;
      !req_out.valid && trap_in == 10'h100 && !overflow_flag_in
         && special_in == '0 && periph_pend_out == '0 |=> !req_out.valid [*3];
   endproperty
   property p_wdt;
      s_wdt_idle |-> ##2 req_out.valid && req_out.src == IEU_SRC_WDT
         && req_out.vector_addr == 20'h0fff0;
   endproperty
   property p_mask;
      s_periph_rise |-> $past(i_flag_in) && cpu_level_in <
         periph_level_in[(req_out.num - 6'h04) * LVL_W +: LVL_W];
   endproperty
   property p_latch;
      |periph_req_in |=>
         (periph_pend_out & $past(periph_req_in)) == $past(periph_req_in);
   endproperty

   a_hold: assert property (p_hold)
      else $error("request changed before ack");
   a_save: assert property (p_save)
      else $error("stack flag not pushed and cleared");
   a_int: assert property (p_int)
      else $error("numbered entry or save wrong");
   a_fixed: assert property (p_fixed)
      else $error("fixed vector address wrong");
   a_undef: assert property (p_undef)
      else $error("undefined opcode not presented");
   a_ovf_drop: assert property (p_ovf_drop)
      else $error("overflow trap taken with flag clear");
   a_wdt: assert property (p_wdt)
      else $error("watchdog not presented");
   a_mask: assert property (p_mask)
      else $error("masked peripheral presented");
   a_latch: assert property (p_latch)
      else $error("peripheral request not latched");
endmodule : ieu_checker

bind ieu_exception_unit ieu_checker #(
   .N_PERIPH(N_PERIPH), .LVL_W(LVL_W), .ADDR_W(ADDR_W)
) u_chk (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .i_flag_in(i_flag_in),
   .cpu_level_in(cpu_level_in), .overflow_flag_in(overflow_flag_in),
   .trap_in(trap_in), .brk_use_reloc_in(brk_use_reloc_in),
   .special_in(special_in), .vector_base_reg_in(vector_base_reg_in),
   .periph_req_in(periph_req_in), .periph_level_in(periph_level_in),
   .ack_in(ack_in), .req_out(req_out), .u_push_out(u_push_out),
   .u_push_val_out(u_push_val_out), .u_flag_out(u_flag_out),
   .periph_pend_out(periph_pend_out)
);

/* File: dv/tb_ieu_exception_unit.sv */
`timescale 1ns/1ps
module tb_ieu_exception_unit;
   import ieu_pkg::*;
   localparam logic [19:0] BASE = 20'h0c000;
   logic clock_in, rst_n_in, i_flag_in, overflow_flag_in, brk_use_reloc_in;
   logic fetch_valid_in, match_enable_0_in, match_enable_1_in, slow, took;
   logic ack_in, return_in, return_restore_u_in, return_u_in;
   logic u_write_in, u_write_val_in, u_push_out, u_push_val_out, u_flag_out;
   logic [2:0]  cpu_level_in;
   logic [19:0] fetch_addr_in, match_address_0_in, match_address_1_in;
   logic [19:0] vector_base_reg_in;
   logic [27:0] periph_req_in, periph_pend_out;
   logic [83:0] periph_level_in;
   ieu_trap_s    trap_in;
   ieu_special_s special_in;
   ieu_req_s     req_out, taken;
   int error_cnt, comparisons, i;
   int nums[5] = '{32, 63, 0, 4, 31};
   ieu_src_e ss[5] = '{IEU_SRC_WDT, IEU_SRC_OSC, IEU_SRC_VMON2,
                       IEU_SRC_SSTEP, IEU_SRC_ABRK};
   logic [19:0] sv[5] = '{20'h0fff0, 20'h0fff0, 20'h0fff0,
                          20'h0ffec, 20'h0fff4};

   ieu_exception_unit dut (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .i_flag_in(i_flag_in),
      .cpu_level_in(cpu_level_in), .overflow_flag_in(overflow_flag_in),
      .trap_in(trap_in), .brk_use_reloc_in(brk_use_reloc_in),
      .special_in(special_in), .fetch_valid_in(fetch_valid_in),
      .fetch_addr_in(fetch_addr_in), .match_address_0_in(match_address_0_in),
      .match_address_1_in(match_address_1_in),
      .match_enable_0_in(match_enable_0_in),
      .match_enable_1_in(match_enable_1_in),
      .vector_base_reg_in(vector_base_reg_in),
      .periph_req_in(periph_req_in), .periph_level_in(periph_level_in),
      .ack_in(ack_in), .return_in(return_in),
      .return_restore_u_in(return_restore_u_in), .return_u_in(return_u_in),
      .u_write_in(u_write_in), .u_write_val_in(u_write_val_in),
      .req_out(req_out), .u_push_out(u_push_out),
      .u_push_val_out(u_push_val_out), .u_flag_out(u_flag_out),
      .periph_pend_out(periph_pend_out));

   ieu_seq_model seq (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .req_in(req_out), .slow_in(slow), .ack_out(ack_in), .took_out(took),
      .taken_out(taken));

   // Free-running core clock, 100 ns period
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One-cycle trap or special pulse, launched off a rising edge
   task fire(input ieu_trap_s t, input ieu_special_s s);
      @(posedge clock_in);
      trap_in    <= t;
      special_in <= s;
      @(posedge clock_in);
      trap_in    <= '0;
      special_in <= '0;
   endtask : fire

   task fetch(input logic [19:0] a);
      @(posedge clock_in);
      fetch_valid_in <= 1'b1;
      fetch_addr_in  <= a;
      @(posedge clock_in);
      fetch_valid_in <= 1'b0;
   endtask : fetch

   // Bounded wait for the sequencer to take a request, then compare it
   task take(input ieu_src_e s, input logic [19:0] va, input logic su);
      int n;
      n = 0;
      do begin
         @(posedge clock_in);
         #1;
         n++;
      end while (took !== 1'b1 && n < 60);
      chk("took", 1, took);
      chk("src", s, taken.src);
      chk("vector", va, taken.vector_addr);
      chk("save", su, taken.save_u);
   endtask : take

   // Nothing may be presented after an eight-cycle wait; only that last cycle is sampled
   task quiet;
      repeat (8) @(posedge clock_in);
      #1 chk("valid", 0, req_out.valid);
   endtask : quiet

   task results;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   // A hang is cut off after 4000 cycles, well past the few hundred cycles the tests need
   initial begin
      #400000;
      error_cnt++;
      results();
   end

   initial begin
      {rst_n_in, i_flag_in, overflow_flag_in, brk_use_reloc_in, slow} = '0;
      {fetch_valid_in, match_enable_0_in, match_enable_1_in} = '0;
      {return_in, return_restore_u_in, return_u_in} = '0;
      {u_write_in, u_write_val_in, periph_req_in} = '0;
      trap_in = '0;
      special_in = '0;
      cpu_level_in = 3'h1;
      fetch_addr_in = 20'h0;
      vector_base_reg_in = BASE;
      match_address_0_in = 20'h01234;
      match_address_1_in = 20'h05678;
      periph_level_in = '0;
      periph_level_in[2:0] = 3'h1;
      periph_level_in[8:6] = 3'h2;
      periph_level_in[17:15] = 3'h6;
      repeat (2) @(posedge clock_in);
      rst_n_in <= 1'b1;
      fire(10'h200, '0);
      take(IEU_SRC_UNDEF, 20'h0ffdc, 1);
      fire(10'h100, '0);
      quiet();
      overflow_flag_in <= 1'b1;
      fire(10'h100, '0);
      take(IEU_SRC_OVF, 20'h0ffe0, 1);
      fire(10'h080, '0);
      take(IEU_SRC_BRK, 20'h0ffe4, 1);
      brk_use_reloc_in <= 1'b1;
      vector_base_reg_in <= 20'h0a400; // A moved base must be followed
      fire(10'h080, '0);
      take(IEU_SRC_BRK, 20'h0a400, 1);
      brk_use_reloc_in <= 1'b0;
      vector_base_reg_in <= BASE;
      {return_in, return_restore_u_in, return_u_in} <= 3'h7;
      @(posedge clock_in);
      return_in <= 1'b0;
      #1 chk("flag", 1, u_flag_out);
      // A return that does not restore leaves the flag alone
      {return_in, return_restore_u_in, return_u_in} <= 3'h4;
      @(posedge clock_in);
      return_in <= 1'b0;
      #1 chk("flag", 1, u_flag_out);
      slow <= 1'b1;
      // Flag set: upper numbers keep it, lower ones clear it
      for (i = 0; i < 5; i++) begin
         fire(10'(10'h040 | nums[i]), '0);
         take(IEU_SRC_INT, BASE + 20'(4 * nums[i]), nums[i] < 32);
         chk("flag", i < 2, u_flag_out);
         chk("push", nums[i] < 32, u_push_out);
         chk("push_val", i == 2, u_push_val_out);
      end
      {u_write_in, u_write_val_in} <= 2'h3;
      @(posedge clock_in);
      u_write_in <= 1'b0;
      // Watchdog, oscillator-stop, voltage-monitor, step and break sources are raised here one at a time
      for (i = 0; i < 5; i++) begin
         fire('0, 5'h10 >> i);
         take(ss[i], sv[i], 1);
      end
      slow <= 1'b0;
      fetch(20'h01234);
      quiet();
      {match_enable_0_in, match_enable_1_in} <= 2'h3;
      fetch(20'h01234);
      take(IEU_SRC_MATCH, 20'h0ffe8, 1);
      fetch(20'h05678);
      take(IEU_SRC_MATCH, 20'h0ffe8, 1);
      periph_req_in <= 28'h25;
      @(posedge clock_in);
      periph_req_in <= '0;
      quiet();
      chk("pend", 28'h25, periph_pend_out);
      i_flag_in <= 1'b1;
      take(IEU_SRC_PERIPH, BASE + 20'd36, 1);
      take(IEU_SRC_PERIPH, BASE + 20'd24, 1);
      quiet();
      chk("pend", 28'h01, periph_pend_out);
      fire(10'h280, 5'h10);
      take(IEU_SRC_UNDEF, 20'h0ffdc, 1);
      take(IEU_SRC_BRK, 20'h0ffe4, 1);
      take(IEU_SRC_WDT, 20'h0fff0, 1);
      results();
   end
endmodule : tb_ieu_exception_unit
